// ===== core/mbsfe_map.svh
// Address values, register offsets, field positions and reset values of the
// monitor bus slave front end. Included by the top-level design file.
`ifndef MBSFE_MAP_SVH
`define MBSFE_MAP_SVH

`define MBSFE_ADDR_DEFAULT 7'h2E
`define MBSFE_ADDR_SEL_LO  7'h2C
`define MBSFE_ADDR_SEL_HI  7'h2D

`define MBSFE_OFS_CFG      8'h00
`define MBSFE_OFS_STATUS   8'h01
`define MBSFE_OFS_MASK     8'h02
`define MBSFE_OFS_VALUE    8'h10
`define MBSFE_OFS_LOW      8'h14
`define MBSFE_OFS_HIGH     8'h18
`define MBSFE_OFS_OFFSET   8'h1C

`define MBSFE_CFG_START    0
`define MBSFE_CFG_ALERT_A  1
`define MBSFE_CFG_ALERT_B  2
`define MBSFE_STAT_LOW_POS 3

`define MBSFE_CFG_RST      8'h00
`define MBSFE_MASK_RST     8'h00
`define MBSFE_LOW_RST      8'h00
`define MBSFE_HIGH_RST     8'h7F
`define MBSFE_OFFSET_RST   8'h00

`endif

// ===== core/mbsfe_pkg.sv
// Types shared by the monitor bus slave front end.
// Assumes the map header sits in the include path.
package mbsfe_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_WAIT,
    ST_ACK_HOLD,
    ST_RX,
    ST_TX,
    ST_MACK
  } mbsfe_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic addr_en;
    logic addr_sel;
  } mbsfe_line_s;

endpackage : mbsfe_pkg

// ===== core/mbsfe_line_sync.sv
// Pin conditioner: synchronises the serial bus lines and the address straps
// to sys_clk and finds clock edges and start and stop conditions.
// Assumes all four inputs are asynchronous pins.
`timescale 1ns/100ps
module mbsfe_line_sync (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               scl_pin,
  input  wire logic               sda_pin,
  input  wire logic               addr_en_pin,
  input  wire logic               addr_sel_pin,
  output mbsfe_pkg::mbsfe_line_s  line
);
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [1:0] last_reg;

  // The first stage feeds the second stage only.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= 4'h3;
      sync_reg <= 4'h3;
    end else begin
      meta_reg <= {addr_sel_pin, addr_en_pin, sda_pin, scl_pin};
      sync_reg <= meta_reg;
    end
  end

  // Idle bus lines are high, so a reset never fakes an edge.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      last_reg <= 2'h3;
    end else begin
      last_reg <= sync_reg[1:0];
    end
  end

  always_comb begin
    line.scl      = sync_reg[0];
    line.sda      = sync_reg[1];
    line.addr_en  = sync_reg[2];
    line.addr_sel = sync_reg[3];
    line.scl_rise = sync_reg[0] & ~last_reg[0];
    line.scl_fall = ~sync_reg[0] & last_reg[0];
    line.start    = sync_reg[0] & last_reg[0] & ~sync_reg[1] & last_reg[1];
    line.stop     = sync_reg[0] & last_reg[0] & sync_reg[1] & ~last_reg[1];
  end

endmodule : mbsfe_line_sync

// ===== core/mbsfe_top.sv
// Serial management bus slave front end of a thermal monitor: strap-chosen
// slave address, address pointer, value, limit, offset, status and mask
// registers, a round-robin measurement store and an open-drain alert.
// Assumes measurement samples arrive on sys_clk; bus pins are asynchronous.
// Functional notes
// - Straps sampled until the first address match choose slave address.
// - Enable strap high selects address 2E.
// - Enable strap low: select picks 2C or 2D.
// - Seven-bit address, slave only.
// - Address latched at eighth clock of match.
// - After latching, strap changes are ignored.
// - First write byte loads the address pointer.
// - All control reached only over serial bus.
// - Sequence stores each channel in its value.
// - Out-of-limit results set readable status bits.
// - Unmasked status drives alert output low.
// - Each status event has its own mask.
// - Alert may use either of two pins.
// - Signed offset added to temperature readings.
// - Writes carry one or two bytes; reads one.
// - Reads return register selected by pointer.
`timescale 1ns/100ps
`include "mbsfe_map.svh"
module mbsfe_top #(
  parameter int NCH = 3
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_en_strap,
  input  wire logic        addr_sel_strap,
  input  wire logic        meas_valid,
  input  wire logic [7:0]  meas_data,
  output logic [1:0]       meas_chan,
  output logic             meas_run,
  output logic             alert_pin_a_o,
  output logic             alert_pin_a_oe,
  output logic             alert_pin_b_o,
  output logic             alert_pin_b_oe,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             irq
);
  mbsfe_pkg::mbsfe_line_s  ev;
  mbsfe_pkg::mbsfe_state_e state_reg;
  logic [2:0]  cnt_reg;
  logic [6:0]  shift_reg;
  logic        rw_reg;
  logic [1:0]  byte_idx_reg;
  logic        oe_reg;
  logic [7:0]  tx_reg;
  logic [6:0]  sel_addr_reg;
  logic        addr_lock_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  cfg_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [7:0]  mask_reg;
  logic [7:0]  value_reg [NCH];
  logic [7:0]  low_reg   [NCH];
  logic [7:0]  high_reg  [NCH];
  logic [7:0]  offs_reg  [NCH];
  logic [1:0]  chan_reg;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        rx_done;
  logic        ser_wr;
  logic [7:0]  rd_ser;
  logic [7:0]  cmp_vec;
  logic        alert;

  mbsfe_line_sync u_sync (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .scl_pin      (scl_i),
    .sda_pin      (sda_i),
    .addr_en_pin  (addr_en_strap),
    .addr_sel_pin (addr_sel_strap),
    .line         (ev)
  );

  function automatic logic [6:0] addr_pick(input logic en, input logic sel);
    if (en) begin
      return `MBSFE_ADDR_DEFAULT;
    end
    return sel ? `MBSFE_ADDR_SEL_HI : `MBSFE_ADDR_SEL_LO;
  endfunction : addr_pick

  // Index of addr inside a bank of NCH registers at base, or NCH if outside.
  function automatic int bank_idx(input logic [7:0] addr, input logic [7:0] base);
    if (addr >= base && addr < base + 8'(NCH)) begin
      return int'(addr - base);
    end
    return NCH;
  endfunction : bank_idx

  function automatic logic [7:0] rd_mux(input logic [7:0] addr);
    int i;
    logic [7:0] r;
    r = 8'h00;
    if (addr == `MBSFE_OFS_CFG) r = cfg_reg;
    if (addr == `MBSFE_OFS_STATUS) r = status_reg;
    if (addr == `MBSFE_OFS_MASK) r = mask_reg;
    i = bank_idx(addr, `MBSFE_OFS_VALUE);
    if (i < NCH) r = value_reg[i];
    i = bank_idx(addr, `MBSFE_OFS_LOW);
    if (i < NCH) r = low_reg[i];
    i = bank_idx(addr, `MBSFE_OFS_HIGH);
    if (i < NCH) r = high_reg[i];
    i = bank_idx(addr, `MBSFE_OFS_OFFSET);
    if (i < NCH) r = offs_reg[i];
    return r;
  endfunction : rd_mux

  // Channel 0 is the voltage input and unsigned; the rest are signed.
  function automatic logic beyond(input logic [7:0] v, input logic [7:0] lim,
                                  input logic sgn, input logic hi);
    logic [8:0] a;
    logic [8:0] b;
    a = {sgn & v[7], v};
    b = {sgn & lim[7], lim};
    return hi ? ($signed(a) > $signed(b)) : ($signed(a) < $signed(b));
  endfunction : beyond

  // Straps follow the pins until the first match, then freeze until the next reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_addr_reg  <= `MBSFE_ADDR_DEFAULT;
      addr_lock_reg <= 1'b0;
    end else begin
      if (!addr_lock_reg) begin
        sel_addr_reg <= addr_pick(ev.addr_en, ev.addr_sel);
      end
      if (byte_done && state_reg == mbsfe_pkg::ST_ADDR && shift_reg == sel_addr_reg) begin
        addr_lock_reg <= 1'b1;
      end
    end
  end

  assign byte_done = ev.scl_rise && cnt_reg == 3'h7;
  assign rx_byte   = {shift_reg, ev.sda};
  assign rx_done   = byte_done && state_reg == mbsfe_pkg::ST_RX && byte_idx_reg < 2'h2;
  assign ser_wr    = rx_done && byte_idx_reg == 2'h1;

  // A process, not an assign, so that a write to the selected register is seen at once.
  always_comb begin
    rd_ser = rd_mux(ptr_reg);
  end

  // Slave-only byte engine; it never drives the clock line.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg    <= mbsfe_pkg::ST_IDLE;
      cnt_reg      <= 3'h0;
      shift_reg    <= 7'h00;
      rw_reg       <= 1'b0;
      byte_idx_reg <= 2'h0;
      oe_reg       <= 1'b0;
      tx_reg       <= 8'hFF;
    end else if (ev.stop) begin
      state_reg <= mbsfe_pkg::ST_IDLE;
      oe_reg    <= 1'b0;
    end else if (ev.start) begin
      state_reg    <= mbsfe_pkg::ST_ADDR;
      cnt_reg      <= 3'h0;
      byte_idx_reg <= 2'h0;
      oe_reg       <= 1'b0;
    end else begin
      unique case (state_reg)
        mbsfe_pkg::ST_IDLE: begin
        end
        mbsfe_pkg::ST_ADDR, mbsfe_pkg::ST_RX: begin
          if (ev.scl_rise) begin
            shift_reg <= rx_byte[6:0];
            cnt_reg   <= cnt_reg + 3'h1;
          end
          if (byte_done && state_reg == mbsfe_pkg::ST_ADDR) begin
            if (shift_reg == sel_addr_reg) begin
              rw_reg    <= ev.sda;
              state_reg <= mbsfe_pkg::ST_ACK_WAIT;
            end else begin
              state_reg <= mbsfe_pkg::ST_IDLE;
            end
          end else if (byte_done) begin
            if (byte_idx_reg < 2'h2) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
              state_reg    <= mbsfe_pkg::ST_ACK_WAIT;
            end else begin
              state_reg <= mbsfe_pkg::ST_IDLE;
            end
          end
        end
        mbsfe_pkg::ST_ACK_WAIT: begin
          if (ev.scl_fall) begin
            oe_reg    <= 1'b1;
            state_reg <= mbsfe_pkg::ST_ACK_HOLD;
          end
        end
        mbsfe_pkg::ST_ACK_HOLD: begin
          if (ev.scl_fall) begin
            cnt_reg <= 3'h0;
            if (rw_reg) begin
              oe_reg    <= ~rd_ser[7];
              tx_reg    <= {rd_ser[6:0], 1'b1};
              state_reg <= mbsfe_pkg::ST_TX;
            end else begin
              oe_reg    <= 1'b0;
              state_reg <= mbsfe_pkg::ST_RX;
            end
          end
        end
        mbsfe_pkg::ST_TX: begin
          if (ev.scl_rise) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              state_reg <= mbsfe_pkg::ST_MACK;
            end
          end
          if (ev.scl_fall) begin
            oe_reg <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b1};
          end
        end
        mbsfe_pkg::ST_MACK: begin
          // One byte per read: the line is released whatever the master answers.
          if (ev.scl_fall) begin
            oe_reg    <= 1'b0;
            state_reg <= mbsfe_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_reg <= 8'h00;
    end else if (rx_done && byte_idx_reg == 2'h0) begin
      ptr_reg <= rx_byte;
    end
  end

  // Only serial writes reach the control state; the plain port reads only.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_reg  <= `MBSFE_CFG_RST;
      mask_reg <= `MBSFE_MASK_RST;
      for (int i = 0; i < NCH; i++) begin
        low_reg[i]  <= `MBSFE_LOW_RST;
        high_reg[i] <= `MBSFE_HIGH_RST;
        offs_reg[i] <= `MBSFE_OFFSET_RST;
      end
    end else if (ser_wr) begin
      if (ptr_reg == `MBSFE_OFS_CFG) cfg_reg <= rx_byte;
      if (ptr_reg == `MBSFE_OFS_MASK) mask_reg <= rx_byte;
      for (int i = 0; i < NCH; i++) begin
        if (bank_idx(ptr_reg, `MBSFE_OFS_LOW) == i) low_reg[i] <= rx_byte;
        if (bank_idx(ptr_reg, `MBSFE_OFS_HIGH) == i) high_reg[i] <= rx_byte;
        if (bank_idx(ptr_reg, `MBSFE_OFS_OFFSET) == i) offs_reg[i] <= rx_byte;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux(reg_addr);
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Round robin over the channels while the start bit is set.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chan_reg <= 2'h0;
      for (int i = 0; i < NCH; i++) begin
        value_reg[i] <= 8'h00;
      end
    end else if (meas_valid && cfg_reg[`MBSFE_CFG_START]) begin
      value_reg[chan_reg] <= (chan_reg == 2'h0) ? meas_data
                             : meas_data + offs_reg[chan_reg];
      chan_reg <= (chan_reg == 2'(NCH - 1)) ? 2'h0 : chan_reg + 2'h1;
    end
  end

  assign meas_chan = chan_reg;
  assign meas_run  = cfg_reg[`MBSFE_CFG_START];

  always_comb begin
    cmp_vec = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      cmp_vec[i] = beyond(value_reg[i], high_reg[i], i != 0, 1'b1);
      cmp_vec[i + `MBSFE_STAT_LOW_POS] = beyond(value_reg[i], low_reg[i], i != 0, 1'b0);
    end
  end

  // A comparison that fires in the cycle of a write-one clear keeps its bit.
  always_comb begin
    status_next = status_reg;
    if (ser_wr && ptr_reg == `MBSFE_OFS_STATUS) begin
      status_next = status_reg & ~rx_byte;
    end
    status_next = status_next | cmp_vec;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  assign alert          = |(status_reg & ~mask_reg);
  assign irq            = alert;
  assign alert_pin_a_o  = 1'b0;
  assign alert_pin_b_o  = 1'b0;
  assign alert_pin_a_oe = alert & cfg_reg[`MBSFE_CFG_ALERT_A];
  assign alert_pin_b_oe = alert & cfg_reg[`MBSFE_CFG_ALERT_B];

  a_addr_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!addr_lock_reg && ev.addr_en) |=> sel_addr_reg == `MBSFE_ADDR_DEFAULT)
    else $error("default address not chosen");

  a_addr_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!addr_lock_reg && !ev.addr_en) |=>
      sel_addr_reg == ($past(ev.addr_sel) ? `MBSFE_ADDR_SEL_HI : `MBSFE_ADDR_SEL_LO))
    else $error("strap address wrong");

  a_addr_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    addr_lock_reg |=> addr_lock_reg && $stable(sel_addr_reg))
    else $error("address changed after latch");

  a_addr_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(addr_lock_reg) |-> $past(ev.scl_rise) && $past(cnt_reg) == 3'h7
      && $past(state_reg) == mbsfe_pkg::ST_ADDR)
    else $error("address latched at wrong edge");

  a_nack_foreign: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == mbsfe_pkg::ST_ADDR && byte_done && !ev.stop && !ev.start
      && shift_reg != sel_addr_reg) |=> (state_reg == mbsfe_pkg::ST_IDLE && !sda_oe) [*2])
    else $error("foreign address acknowledged");

  a_ptr_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx_done && byte_idx_reg == 2'h0 && !ev.start && !ev.stop) |=> ptr_reg == $past(rx_byte))
    else $error("pointer not loaded by first byte");

  a_offset_add: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (meas_valid && meas_run && meas_chan == 2'h1) |=>
      value_reg[1] == 8'($past(meas_data) + $past(offs_reg[1])))
    else $error("offset not applied");

  a_status_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_vec != 8'h00) |=> (status_reg & $past(cmp_vec)) == $past(cmp_vec))
    else $error("limit event lost");

  a_alert_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((status_reg & ~mask_reg) == 8'h00) |-> !alert_pin_a_oe && !alert_pin_b_oe && !irq)
    else $error("masked event drives alert");

  a_one_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == mbsfe_pkg::ST_MACK && ev.scl_fall && !ev.start && !ev.stop) |=>
      state_reg == mbsfe_pkg::ST_IDLE && !sda_oe)
    else $error("read went past one byte");

endmodule : mbsfe_top

// ===== verif/mbsfe_bus_master.sv
// Serial management bus master model for the monitor front end bench.
// Assumes the bench resolves the open-drain data wire with a pull-up and
// calls each transfer right after a rising edge of sys_clk.
`timescale 1ns/100ps
module mbsfe_bus_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  localparam real Q = 16.0;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // The small skew keeps every bus edge away from the sampling clock's edges.
  task automatic start();
    #0.7;
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
  endtask : start

  task automatic clk_bit(input logic b, output logic r);
    #Q sda_drv = b;
    #Q scl = 1'b1;
    #Q r = sda_wire;
    #Q scl = 1'b0;
  endtask : clk_bit

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask : send

  // A single byte is taken and refused, so the device stops driving.
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(1'b1, r);
  endtask : recv

  // The clock stands high after the stop until the next frame.
  task automatic stop();
    #Q sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop
endmodule : mbsfe_bus_master

// ===== verif/mbsfe_top_bench.sv
// Self-checking bench of the monitor bus slave front end.
// Assumes the bus master model and a pull-up on the data wire.
`timescale 1ns/100ps
module mbsfe_top_bench;
  logic       sys_clk, rst_n, en_s, sel_s, meas_valid, reg_wr, reg_rd;
  logic [7:0] meas_data, reg_addr, reg_wdata, reg_rdata;
  logic       sda_o, sda_oe, meas_run, a_o, a_oe, b_o, b_oe, irq;
  logic [1:0] meas_chan;
  logic [6:0] dev;
  wire        scl_w, m_sda;
  wire        sda_w = m_sda & ~(sda_oe & ~sda_o);
  int         miscompares, tests_run;

  mbsfe_bus_master m_u (.scl(scl_w), .sda_drv(m_sda), .sda_wire(sda_w));

  mbsfe_top #(.NCH(3)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_en_strap(en_s), .addr_sel_strap(sel_s),
    .meas_valid(meas_valid), .meas_data(meas_data), .meas_chan(meas_chan),
    .meas_run(meas_run), .alert_pin_a_o(a_o), .alert_pin_a_oe(a_oe),
    .alert_pin_b_o(b_o), .alert_pin_b_oe(b_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check1

  task automatic do_reset(input logic en, input logic sel);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    en_s  <= en;
    sel_s <= sel;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : do_reset

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check8("reg_rdata", exp, reg_rdata);
  endtask : reg_read

  task automatic ser_write(input logic [6:0] a, input logic [7:0] p, input logic has_d,
                           input logic [7:0] d, input logic exp_ack);
    logic ack;
    @(posedge sys_clk);
    m_u.start();
    m_u.send({a, 1'b0}, ack);
    check1("address ack", exp_ack, ack);
    if (ack) begin
      m_u.send(p, ack);
      check1("pointer ack", 1'b1, ack);
      if (has_d) begin
        m_u.send(d, ack);
        check1("data ack", 1'b1, ack);
      end
    end
    m_u.stop();
  endtask : ser_write

  task automatic ser_read(input logic [7:0] exp);
    logic       ack;
    logic [7:0] d;
    @(posedge sys_clk);
    m_u.start();
    m_u.send({dev, 1'b1}, ack);
    check1("read ack", 1'b1, ack);
    m_u.recv(d);
    m_u.stop();
    check8("serial read", exp, d);
  endtask : ser_read

  task automatic t_reset();
    check1("sda_oe", 1'b0, sda_oe);
    check1("irq", 1'b0, irq);
    check1("meas_run", 1'b0, meas_run);
    check1("alert a level", 1'b0, a_o);
    check1("alert b level", 1'b0, b_o);
    reg_read(8'h01, 8'h00);
    reg_read(8'h02, 8'h00);
    reg_read(8'h18, 8'h7F);
    reg_read(8'h16, 8'h00);
    reg_read(8'h40, 8'h00);
  endtask : t_reset

  task automatic t_address();
    logic [6:0] good [3] = '{7'h2E, 7'h2C, 7'h2D};
    logic [6:0] bad  [3] = '{7'h2C, 7'h2E, 7'h2C};
    logic [1:0] strap [3] = '{2'b10, 2'b00, 2'b01};
    for (int i = 0; i < 3; i++) begin
      do_reset(strap[i][1], strap[i][0]);
      ser_write(bad[i], 8'h02, 1'b0, 8'h00, 1'b0);
      ser_write(good[i], 8'h02, 1'b0, 8'h00, 1'b1);
      en_s  <= ~strap[i][1];
      sel_s <= ~strap[i][0];
      ser_write(good[i], 8'h02, 1'b0, 8'h00, 1'b1);
    end
    dev = 7'h2D;
  endtask : t_address

  task automatic t_pointer();
    logic ack;
    ser_write(dev, 8'h02, 1'b1, 8'h05, 1'b1);
    ser_read(8'h05);
    ser_read(8'h05);
    reg_read(8'h02, 8'h05);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= 8'h02;
    reg_wdata <= 8'h00;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_read(8'h02, 8'h05);
    @(posedge sys_clk);
    m_u.start();
    m_u.send({dev, 1'b0}, ack);
    m_u.send(8'h18, ack);
    m_u.send(8'h40, ack);
    m_u.send(8'h33, ack);
    check1("third byte ack", 1'b0, ack);
    m_u.stop();
    reg_read(8'h18, 8'h40);
  endtask : t_pointer

  task automatic t_measure();
    logic [7:0] smp [3] = '{8'h10, 8'h30, 8'h08};
    ser_write(dev, 8'h19, 1'b1, 8'h20, 1'b1);
    ser_write(dev, 8'h1D, 1'b1, 8'h05, 1'b1);
    ser_write(dev, 8'h1E, 1'b1, 8'hFE, 1'b1);
    ser_write(dev, 8'h02, 1'b1, 8'h00, 1'b1);
    ser_write(dev, 8'h00, 1'b1, 8'h03, 1'b1);
    check1("meas_run", 1'b1, meas_run);
    for (int i = 0; i < 3; i++) begin
      check8("meas_chan", 8'(i), {6'h00, meas_chan});
      @(posedge sys_clk);
      meas_valid <= 1'b1;
      meas_data  <= smp[i];
      @(posedge sys_clk);
      meas_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    reg_read(8'h10, 8'h10);
    reg_read(8'h11, 8'h35);
    reg_read(8'h12, 8'h06);
    reg_read(8'h01, 8'h02);
    check1("irq", 1'b1, irq);
    check1("alert a", 1'b1, a_oe);
    check1("alert b", 1'b0, b_oe);
    ser_write(dev, 8'h02, 1'b1, 8'h02, 1'b1);
    check1("masked irq", 1'b0, irq);
    check1("masked alert", 1'b0, a_oe);
    ser_write(dev, 8'h02, 1'b1, 8'h00, 1'b1);
    ser_write(dev, 8'h00, 1'b1, 8'h05, 1'b1);
    check1("alert a off", 1'b0, a_oe);
    check1("alert b on", 1'b1, b_oe);
  endtask : t_measure

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // About 50 bus bytes of 0.6 us each fit well inside this span.
  initial begin
    #300000;
    miscompares++;
    conclude();
  end

  initial begin
    rst_n      = 1'b0;
    en_s       = 1'b1;
    sel_s      = 1'b0;
    meas_valid = 1'b0;
    meas_data  = 8'h00;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    dev        = 7'h2E;
    miscompares = 0;
    tests_run   = 0;
    do_reset(1'b1, 1'b0);
    t_reset();
    t_address();
    t_pointer();
    t_measure();
    conclude();
  end
endmodule : mbsfe_top_bench
